// ===== logic/reset_init_pkg.sv
// Purpose: shared constants and types for the reset state initializer
// Assumes: 8-bit managed registers, APB with 32-bit data, 12-bit address
// Notes: reset values are per managed register, indexed by register slot
package reset_init_pkg;
	localparam int NUM_REGS = 8;
	localparam int ADDR_W = 12;
	localparam int NUM_EVT = 5;

	// managed register slots, byte address is slot * 4
	localparam int IDX_PC_LOW = 0;
	localparam int IDX_STACK = 1;
	localparam int IDX_INT_CTRL = 2;
	localparam int IDX_TIMER_CTRL = 3;
	localparam int IDX_PORT_DIR = 4;
	localparam int IDX_ANALOG_SEL = 5;
	localparam int IDX_COUNTER_CTRL = 6;
	localparam int IDX_SCRATCH = 7;

	localparam logic [ADDR_W-1:0] OFS_FLAGS = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 12'h024;
	localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 12'h028;
	localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 12'h02C;

	localparam int FLAG_TIME_OUT_BIT = 0;
	localparam int FLAG_POWER_DOWN_BIT = 1;

	localparam int EVT_POWER_ON = 0;
	localparam int EVT_LOW_VOLT = 1;
	localparam int EVT_WATCH_RUN = 2;
	localparam int EVT_WATCH_HALT = 3;
	localparam int EVT_SLEEP = 4;
	localparam logic [NUM_EVT-1:0] EVT_STATUS_RESET = 5'h01;
	localparam logic [NUM_EVT-1:0] EVT_ENABLE_RESET = 5'h00;

	localparam logic [7:0] STACK_TOP = 8'h07;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ALL_INPUT = 8'hFF;
	localparam logic [7:0] ALL_ANALOG = 8'hFF;

	// power-on and low-voltage column
	localparam logic [7:0] POR_VAL [NUM_REGS] = '{8'h00, STACK_TOP, 8'h00, 8'h00,
		ALL_INPUT, ALL_ANALOG, 8'h53, 8'h00};
	// bits kept by a watchdog overflow in normal or slow mode
	localparam logic [7:0] NORM_KEEP [NUM_REGS] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'hFF};
	// bits kept by a watchdog overflow in idle or sleep mode
	localparam logic [7:0] HALT_KEEP [NUM_REGS] = '{8'h00, 8'h00, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF};
	localparam logic [7:0] HALT_VAL [NUM_REGS] = '{8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00};

	typedef enum logic [1:0] {KIND_NONE, KIND_FULL, KIND_NORMAL, KIND_HALT} reset_kind_t;
endpackage : reset_init_pkg

// ===== logic/reset_apply_if.sv
// Purpose: carries the reset kind from the sequencer to the register slots
// Assumes: kind is a one-cycle request, KIND_NONE when idle
// Notes: write strobe and data share the carrier
`timescale 1ns/1ns
interface reset_apply_if;
	reset_init_pkg::reset_kind_t kind;
	logic [reset_init_pkg::NUM_REGS-1:0] wr_en;
	logic [7:0] wr_data;
	modport ctrl (output kind, output wr_en, output wr_data);
	modport unit (input kind, input wr_en, input wr_data);
endinterface : reset_apply_if

// ===== logic/reset_value_unit.sv
// Purpose: one managed register with its three reset columns
// Assumes: reset request and software write never meet; reset wins if they do
// Notes: slot number selects the column constants
`timescale 1ns/1ns
module reset_value_unit #(
	parameter int IDX = 0
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // power-on reset, active low
	reset_apply_if.unit rk, // reset kind and write strobes
	output logic [7:0] value // current register value
);
	logic [7:0] value_reg;
	logic [7:0] value_next;
	wire [7:0] full_v = reset_init_pkg::POR_VAL[IDX];
	wire [7:0] norm_v = (value_reg & reset_init_pkg::NORM_KEEP[IDX])
		| (reset_init_pkg::POR_VAL[IDX] & ~reset_init_pkg::NORM_KEEP[IDX]);
	wire [7:0] halt_v = (value_reg & reset_init_pkg::HALT_KEEP[IDX])
		| (reset_init_pkg::HALT_VAL[IDX] & ~reset_init_pkg::HALT_KEEP[IDX]);
	wire [7:0] sw_v = rk.wr_en[IDX] ? rk.wr_data : value_reg;

	always_comb begin
		unique case (rk.kind)
			reset_init_pkg::KIND_FULL: value_next = full_v;
			reset_init_pkg::KIND_NORMAL: value_next = norm_v;
			reset_init_pkg::KIND_HALT: value_next = halt_v;
			reset_init_pkg::KIND_NONE: value_next = sw_v;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value_reg <= reset_init_pkg::POR_VAL[IDX];
		end else begin
			value_reg <= value_next;
		end
	end

	assign value = value_reg;
endmodule : reset_value_unit

// ===== logic/reset_state_initializer.sv
// Purpose: applies reset state and reset-cause flags per reset cause
// Assumes: cause inputs are one-cycle pulses synchronous to pclk
// Notes: presetn is the power-on reset; APB slave, zero wait states
`timescale 1ns/1ns
// Overview of operation
// - keep time-out and power-down cause flags
// - power-on clears flags; low-voltage keeps them
// - run-mode watchdog overflow sets time-out only
// - halt-mode watchdog overflow sets both flags
// - power-on disables every interrupt source
// - power-on clears watchdog, counting starts
// - power-on leaves timer switched off
// - power-on: pins inputs, analog pins converter
// - power-on: counter zero, stack at top
// - registers take the column of reset type
// - halt-mode overflow zeroes counter and stack
module reset_state_initializer (
	input wire logic pclk, // system clock, 100 MHz
	input wire logic presetn, // power-on reset, active low
	input wire logic [reset_init_pkg::ADDR_W-1:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic low_voltage_reset, // low-voltage reset pulse
	input wire logic watchdog_overflow, // watchdog overflow pulse
	input wire logic halt_mode, // high in idle or sleep mode
	input wire logic sleep_enter, // pulse on idle or sleep entry
	output logic time_out_flag, // watchdog time-out cause flag
	output logic power_down_flag, // power-down cause flag
	output logic [7:0] program_counter_low_byte, // program counter low byte
	output logic [7:0] stack_pointer, // stack pointer
	output logic [7:0] int_enable, // interrupt source enables
	output logic [7:0] timer_control, // timer/event counter control
	output logic [7:0] port_direction, // port direction, 1 is input
	output logic [7:0] analog_input_pins, // converter pin select
	output logic [7:0] counter_control, // watchdog control
	output logic watchdog_overflow_counter_clear, // clears watchdog counter
	output logic irq // level interrupt
);
	localparam int N = reset_init_pkg::NUM_REGS;
	localparam int NE = reset_init_pkg::NUM_EVT;

	reset_apply_if rk ();

	logic [7:0] reg_val [N];
	logic time_out_reg;
	logic time_out_next;
	logic power_down_reg;
	logic power_down_next;
	logic [NE-1:0] evt_status_reg;
	logic [NE-1:0] evt_status_next;
	logic [NE-1:0] evt_enable_reg;
	logic [NE-1:0] evt_enable_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic counter_clear_reg;
	logic power_on_pending_reg;

	function automatic logic is_slot(input logic [reset_init_pkg::ADDR_W-1:0] a);
		is_slot = (a[1:0] == 2'b00) && (a[reset_init_pkg::ADDR_W-1:2] < N);
	endfunction : is_slot

	function automatic logic is_mapped(input logic [reset_init_pkg::ADDR_W-1:0] a);
		is_mapped = is_slot(a) || a == reset_init_pkg::OFS_FLAGS
			|| a == reset_init_pkg::OFS_EVT_STATUS || a == reset_init_pkg::OFS_EVT_CLEAR
			|| a == reset_init_pkg::OFS_EVT_ENABLE;
	endfunction : is_mapped

	// cause decode; low voltage outranks a coincident watchdog overflow
	wire watch_run = watchdog_overflow && !low_voltage_reset && !halt_mode;
	wire watch_halt = watchdog_overflow && !low_voltage_reset && halt_mode;
	wire sleep_only = sleep_enter && !low_voltage_reset && !watchdog_overflow;

	// apb decode
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire wr_access = access && pwrite && is_mapped(paddr);
	wire [reset_init_pkg::ADDR_W-3:0] slot = paddr[reset_init_pkg::ADDR_W-1:2];
	wire wr_slot = wr_access && is_slot(paddr);
	wire wr_clear = wr_access && paddr == reset_init_pkg::OFS_EVT_CLEAR;
	wire wr_enable = wr_access && paddr == reset_init_pkg::OFS_EVT_ENABLE;

	assign rk.kind = low_voltage_reset ? reset_init_pkg::KIND_FULL
		: watch_run ? reset_init_pkg::KIND_NORMAL
		: watch_halt ? reset_init_pkg::KIND_HALT
		: reset_init_pkg::KIND_NONE;
	assign rk.wr_data = pwdata[7:0];

	// one-hot strobe; is_slot has already bounded the slot number
	assign rk.wr_en = wr_slot ? N'(1) << slot : '0;

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_slot
			reset_value_unit #(.IDX(gi)) u_slot (
				.pclk(pclk),
				.presetn(presetn),
				.rk(rk),
				.value(reg_val[gi])
			);
		end
	endgenerate

	// cause flags; a reset cause outranks sleep entry
	always_comb begin
		time_out_next = time_out_reg;
		power_down_next = power_down_reg;
		if (watch_run) begin
			time_out_next = 1'b1;
		end else if (watch_halt) begin
			time_out_next = 1'b1;
			power_down_next = 1'b1;
		end else if (sleep_only) begin
			time_out_next = 1'b0;
			power_down_next = 1'b1;
		end
	end

	// event sticky bits; a set in the clearing cycle survives
	wire [NE-1:0] evt_set = {sleep_only, watch_halt, watch_run, low_voltage_reset,
		power_on_pending_reg};
	wire [NE-1:0] evt_clr = wr_clear ? pwdata[NE-1:0] : '0;
	assign evt_status_next = (evt_status_reg & ~evt_clr) | evt_set;
	assign evt_enable_next = wr_enable ? pwdata[NE-1:0] : evt_enable_reg;

	wire [31:0] flags_word = {30'h0, power_down_reg, time_out_reg};
	wire [31:0] slot_word = {24'h0, reg_val[slot[2:0]]};
	always_comb begin
		prdata_next = 32'h0000_0000;
		if (is_slot(paddr)) begin
			prdata_next = slot_word;
		end else if (paddr == reset_init_pkg::OFS_FLAGS) begin
			prdata_next = flags_word;
		end else if (paddr == reset_init_pkg::OFS_EVT_STATUS) begin
			prdata_next = {27'h0, evt_status_reg};
		end else if (paddr == reset_init_pkg::OFS_EVT_ENABLE) begin
			prdata_next = {27'h0, evt_enable_reg};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_out_reg <= 1'b0;
			power_down_reg <= 1'b0;
		end else begin
			time_out_reg <= time_out_next;
			power_down_reg <= power_down_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_status_reg <= reset_init_pkg::EVT_STATUS_RESET;
			evt_enable_reg <= reset_init_pkg::EVT_ENABLE_RESET;
		end else begin
			evt_status_reg <= evt_status_next;
			evt_enable_reg <= evt_enable_next;
		end
	end

	// read data captured in setup so the access phase sees a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup) begin
			prdata_reg <= prdata_next;
		end
	end

	// watchdog counter cleared right after power-on and every reset cause
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_on_pending_reg <= 1'b1;
			counter_clear_reg <= 1'b1;
		end else begin
			power_on_pending_reg <= 1'b0;
			counter_clear_reg <= low_voltage_reset || watchdog_overflow;
		end
	end

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = access && !is_mapped(paddr);
	assign irq = |(evt_status_reg & evt_enable_reg);
	assign time_out_flag = time_out_reg;
	assign power_down_flag = power_down_reg;
	assign program_counter_low_byte = reg_val[reset_init_pkg::IDX_PC_LOW];
	assign stack_pointer = reg_val[reset_init_pkg::IDX_STACK];
	assign int_enable = reg_val[reset_init_pkg::IDX_INT_CTRL];
	assign timer_control = reg_val[reset_init_pkg::IDX_TIMER_CTRL];
	assign port_direction = reg_val[reset_init_pkg::IDX_PORT_DIR];
	assign analog_input_pins = reg_val[reset_init_pkg::IDX_ANALOG_SEL];
	assign counter_control = reg_val[reset_init_pkg::IDX_COUNTER_CTRL];
	assign watchdog_overflow_counter_clear = counter_clear_reg;

	// checks
	chk_low_volt_flags: assert property (@(posedge pclk) disable iff (!presetn)
		low_voltage_reset |=> time_out_flag == $past(time_out_flag)
			&& power_down_flag == $past(power_down_flag))
		else $error("flags changed on low-voltage reset");

	chk_run_overflow_flags: assert property (@(posedge pclk) disable iff (!presetn)
		watchdog_overflow && !halt_mode && !low_voltage_reset
		|=> time_out_flag && power_down_flag == $past(power_down_flag))
		else $error("run overflow flags wrong");

	chk_halt_overflow_flags: assert property (@(posedge pclk) disable iff (!presetn)
		watchdog_overflow && halt_mode && !low_voltage_reset
		|=> time_out_flag && power_down_flag)
		else $error("halt overflow flags wrong");

	chk_sleep_entry_flags: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_enter && !watchdog_overflow && !low_voltage_reset
		|=> power_down_flag && !time_out_flag)
		else $error("sleep entry flags wrong");

	chk_halt_pc_stack: assert property (@(posedge pclk) disable iff (!presetn)
		watchdog_overflow && halt_mode && !low_voltage_reset
		|=> program_counter_low_byte == 8'h00 && stack_pointer == 8'h00
			&& int_enable == $past(int_enable))
		else $error("halt overflow state wrong");

	chk_full_int_off: assert property (@(posedge pclk) disable iff (!presetn)
		low_voltage_reset |=> int_enable == 8'h00 && !irq || $past(evt_enable_reg) != 5'h00)
		else $error("interrupts not disabled");

	chk_full_timer_off: assert property (@(posedge pclk) disable iff (!presetn)
		low_voltage_reset |=> timer_control == 8'h00)
		else $error("timer not off");

	chk_full_ports_in: assert property (@(posedge pclk) disable iff (!presetn)
		low_voltage_reset |=> port_direction == 8'hFF && analog_input_pins == 8'hFF)
		else $error("ports not inputs");

	chk_full_pc_stack: assert property (@(posedge pclk) disable iff (!presetn)
		low_voltage_reset |=> program_counter_low_byte == 8'h00 && stack_pointer == 8'h07)
		else $error("counter or stack wrong");

	chk_counter_clear: assert property (@(posedge pclk) disable iff (!presetn)
		low_voltage_reset ##1 !low_voltage_reset && !watchdog_overflow
		|-> watchdog_overflow_counter_clear ##1 !watchdog_overflow_counter_clear)
		else $error("watchdog clear pulse wrong");

	chk_run_keep_scratch: assert property (@(posedge pclk) disable iff (!presetn)
		watchdog_overflow && !halt_mode && !low_voltage_reset
		|=> counter_control == 8'h53 && $stable(reg_val[reset_init_pkg::IDX_SCRATCH]))
		else $error("run overflow column wrong");

	chk_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && paddr == 12'h040 |-> pslverr)
		else $error("unmapped access not flagged");

	chk_quiet_flags: assert property (@(posedge pclk) disable iff (!presetn)
		!watchdog_overflow && !sleep_enter
		|=> $stable(time_out_flag) && $stable(power_down_flag))
		else $error("flags moved with no cause");

	chk_run_column: assert property (@(posedge pclk) disable iff (!presetn)
		watchdog_overflow && !halt_mode && !low_voltage_reset
		|=> program_counter_low_byte == 8'h00 && stack_pointer == reset_init_pkg::STACK_TOP
			&& int_enable == 8'h00 && port_direction == 8'hFF)
		else $error("run overflow reset values wrong");

	chk_halt_keep_rest: assert property (@(posedge pclk) disable iff (!presetn)
		watchdog_overflow && halt_mode && !low_voltage_reset
		|=> $stable(timer_control) && $stable(port_direction)
			&& $stable(analog_input_pins) && $stable(counter_control))
		else $error("halt overflow touched kept state");

	// first edge after power-on: clear pulse ends, power-on event stays recorded
	chk_power_on_start: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) && !low_voltage_reset && !watchdog_overflow
		|-> watchdog_overflow_counter_clear ##1 !watchdog_overflow_counter_clear
			&& evt_status_reg[reset_init_pkg::EVT_POWER_ON])
		else $error("power-on start wrong");

	chk_watch_clear: assert property (@(posedge pclk) disable iff (!presetn)
		watchdog_overflow |=> watchdog_overflow_counter_clear)
		else $error("watchdog clear missing after overflow");

	chk_low_volt_status: assert property (@(posedge pclk) disable iff (!presetn)
		low_voltage_reset |=> evt_status_reg[reset_init_pkg::EVT_LOW_VOLT])
		else $error("low-voltage event not recorded");

	// software side of the event registers
	chk_event_clear: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clear |=> (evt_status_reg & $past(evt_clr) & ~$past(evt_set)) == 5'h00)
		else $error("event clear did not take");

	chk_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_enable |=> evt_enable_reg == $past(pwdata[NE-1:0]))
		else $error("enable write did not take");

	cov_run_overflow: cover property (@(posedge pclk) disable iff (!presetn)
		watchdog_overflow && !halt_mode ##1 time_out_flag);
	cov_halt_overflow: cover property (@(posedge pclk) disable iff (!presetn)
		watchdog_overflow && halt_mode ##1 power_down_flag && time_out_flag);
	cov_irq_raised: cover property (@(posedge pclk) disable iff (!presetn)
		!irq ##1 irq);
	cov_sleep_entry: cover property (@(posedge pclk) disable iff (!presetn)
		sleep_enter ##1 power_down_flag && !time_out_flag);
	cov_low_volt: cover property (@(posedge pclk) disable iff (!presetn)
		low_voltage_reset ##1 watchdog_overflow_counter_clear);
endmodule : reset_state_initializer

// ===== tb/testbench.sv
// Purpose: self-checking bench for the reset state initializer over APB
// Assumes: zero-wait APB slave, cause inputs are one-cycle pulses
// Notes: expected columns are built here, not read back from the design
`timescale 1ns/1ns
module testbench;
	logic pclk;
	logic presetn;
	logic [reset_init_pkg::ADDR_W-1:0] paddr;
	logic psel, penable, pwrite, pready, pslverr;
	logic [31:0] pwdata, prdata, rd;
	logic low_voltage_reset, watchdog_overflow, halt_mode, sleep_enter;
	logic time_out_flag, power_down_flag, wd_clear, irq, err_seen;
	logic [7:0] pc_low, stack_pointer, int_enable, timer_control;
	logic [7:0] port_direction, analog_input_pins, counter_control;
	logic [7:0] por_val [8];
	logic [7:0] exp_val [8];
	int errors, check_count;

	reset_state_initializer i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .low_voltage_reset(low_voltage_reset),
		.watchdog_overflow(watchdog_overflow), .halt_mode(halt_mode),
		.sleep_enter(sleep_enter), .time_out_flag(time_out_flag),
		.power_down_flag(power_down_flag), .program_counter_low_byte(pc_low),
		.stack_pointer(stack_pointer), .int_enable(int_enable),
		.timer_control(timer_control), .port_direction(port_direction),
		.analog_input_pins(analog_input_pins), .counter_control(counter_control),
		.watchdog_overflow_counter_clear(wd_clear), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// answer is taken at the edge where pready is seen high, then released
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 50) begin
			errors++;
			summarize();
		end
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd_chk(input logic [11:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0000_0000);
		check(rd, exp);
	endtask : rd_chk

	task automatic flags_chk(input logic t, input logic p);
		check({time_out_flag, power_down_flag}, {t, p});
		rd_chk(reset_init_pkg::OFS_FLAGS, {30'h0, p, t});
	endtask : flags_chk

	task automatic slots_chk();
		for (int i = 0; i < 8; i++) begin
			rd_chk(12'(i * 4), {24'h0, exp_val[i]});
		end
	endtask : slots_chk

	task automatic fill();
		for (int i = 0; i < 8; i++) begin
			exp_val[i] = 8'hC0 | 8'(i);
			apb(1'b1, 12'(i * 4), {24'h0, exp_val[i]});
		end
		slots_chk();
	endtask : fill

	task automatic cause(input logic lv, input logic wd, input logic hm, input logic sl);
		@(posedge pclk);
		low_voltage_reset <= lv;
		watchdog_overflow <= wd;
		halt_mode <= hm;
		sleep_enter <= sl;
		@(posedge pclk);
		low_voltage_reset <= 1'b0;
		watchdog_overflow <= 1'b0;
		sleep_enter <= 1'b0;
		#1;
		check(wd_clear, lv | wd);
		@(posedge pclk);
		#1;
		check(wd_clear, 1'b0);
	endtask : cause

	task automatic write_irq(input logic [11:0] addr, input logic [31:0] data, input logic v);
		apb(1'b1, addr, data);
		#1;
		check(irq, v);
	endtask : write_irq

	task automatic power_on();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		#1;
		check(wd_clear, 1'b1);
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		check(wd_clear, 1'b0);
		check({pc_low, stack_pointer}, {8'h00, reset_init_pkg::STACK_TOP});
		check(int_enable, 8'h00);
		check(timer_control, 8'h00);
		check({port_direction, analog_input_pins}, 16'hFFFF);
		check(counter_control, 8'h53);
		flags_chk(1'b0, 1'b0);
		exp_val = por_val;
		slots_chk();
	endtask : power_on

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		low_voltage_reset = 1'b0;
		watchdog_overflow = 1'b0;
		halt_mode = 1'b0;
		sleep_enter = 1'b0;
		errors = 0;
		check_count = 0;
		por_val = '{8'h00, reset_init_pkg::STACK_TOP, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h53, 8'h00};
		repeat (17) @(posedge pclk);
		power_on();
		rd_chk(reset_init_pkg::OFS_EVT_STATUS, 32'h0000_0001);
		rd_chk(reset_init_pkg::OFS_EVT_ENABLE, 32'h0000_0000);
		// run-mode overflow keeps scratch only
		fill();
		cause(1'b0, 1'b1, 1'b0, 1'b0);
		flags_chk(1'b1, 1'b0);
		exp_val = por_val;
		exp_val[7] = 8'hC7;
		slots_chk();
		cause(1'b0, 1'b0, 1'b0, 1'b1);
		flags_chk(1'b0, 1'b1);
		cause(1'b0, 1'b1, 1'b0, 1'b0);
		flags_chk(1'b1, 1'b1);
		fill();
		cause(1'b1, 1'b0, 1'b0, 1'b0);
		flags_chk(1'b1, 1'b1);
		exp_val = por_val;
		slots_chk();
		rd_chk(reset_init_pkg::OFS_EVT_STATUS, 32'h0000_0017);
		// second power-on in mid-run, then a halt-mode overflow from clear flags
		power_on();
		fill();
		cause(1'b0, 1'b1, 1'b1, 1'b0);
		flags_chk(1'b1, 1'b1);
		exp_val[0] = 8'h00;
		exp_val[1] = 8'h00;
		slots_chk();
		rd_chk(reset_init_pkg::OFS_EVT_STATUS, 32'h0000_0009);
		write_irq(reset_init_pkg::OFS_EVT_ENABLE, 32'h0000_0008, 1'b1);
		write_irq(reset_init_pkg::OFS_EVT_ENABLE, 32'h0000_0000, 1'b0);
		write_irq(reset_init_pkg::OFS_EVT_ENABLE, 32'h0000_0008, 1'b1);
		write_irq(reset_init_pkg::OFS_EVT_CLEAR, 32'h0000_0008, 1'b0);
		rd_chk(reset_init_pkg::OFS_EVT_STATUS, 32'h0000_0001);
		// flags are read-only: a write must not move them
		apb(1'b1, reset_init_pkg::OFS_FLAGS, 32'h0000_0000);
		flags_chk(1'b1, 1'b1);
		rd_chk(12'h040, 32'h0000_0000);
		check(err_seen, 1'b1);
		// low-voltage beats a same-cycle overflow, which leaves no trace
		cause(1'b0, 1'b0, 1'b0, 1'b1);
		cause(1'b1, 1'b1, 1'b0, 1'b0);
		flags_chk(1'b0, 1'b1);
		rd_chk(reset_init_pkg::OFS_EVT_STATUS, 32'h0000_0013);
		summarize();
	end
endmodule : testbench
